// >>> verilog/ccd_pkg.sv
// constants, fields and opcode encodings for the clear/call/decrement core
package ccd_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned PC_W      = 15;
  localparam int unsigned FILE_AW   = 7;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned LATCH_W   = 7;
  localparam int unsigned STACK_D   = 16;
  localparam int unsigned WDT_W     = 8;
  localparam int unsigned PRESC_W   = 8;
  localparam int unsigned CYC_W     = 16;

  // ************************************************************
  // register indices on the plain port
  // ************************************************************
  localparam logic [3:0] REG_INSTR     = 4'h0;
  localparam logic [3:0] REG_WORK      = 4'h1;
  localparam logic [3:0] REG_STATUS    = 4'h2;
  localparam logic [3:0] REG_PC        = 4'h3;
  localparam logic [3:0] REG_LATCH     = 4'h4;
  localparam logic [3:0] REG_STACK_TOP = 4'h5;
  localparam logic [3:0] REG_WDT       = 4'h6;
  localparam logic [3:0] REG_CYCLES    = 4'h7;
  localparam logic [3:0] REG_FILE_ADDR = 4'h8;
  localparam logic [3:0] REG_FILE_DATA = 4'h9;

  // ************************************************************
  // instruction word fields
  // ************************************************************
  localparam int unsigned INSTR_OP_LSB = 8;
  localparam int unsigned INSTR_D_BIT  = 7;

  // ************************************************************
  // status bit positions
  // ************************************************************
  localparam int unsigned ST_ZERO = 0;
  localparam int unsigned ST_TO   = 1;
  localparam int unsigned ST_PD   = 2;
  localparam int unsigned ST_BUSY = 3;

  // ************************************************************
  // reset values and counts
  // ************************************************************
  localparam logic [7:0]  WDT_CLEAR_VALUE = 8'h00;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;
  localparam logic [14:0] PC_RESET        = 15'h0000;
  localparam logic [14:0] PC_STEP         = 15'h0001;
  localparam logic [14:0] PC_SKIP_STEP    = 15'h0002;
  localparam int unsigned TWO_CYCLE_EXTRA = 1;

  typedef enum logic [2:0] {
    no_operation           = 3'h0,
    watchdog_clear_op      = 3'h1,
    call_via_working_op    = 3'h2,
    complement_file_op     = 3'h3,
    clear_file_op          = 3'h4,
    decrement_file_op      = 3'h5,
    clear_working_op       = 3'h6,
    decrement_skip_zero_op = 3'h7
  } ccd_op_t;

endpackage : ccd_pkg

// >>> verilog/ccd_file_regs.sv
// file register space: one write port, one asynchronous read port
`timescale 1ns/1ps
`default_nettype none
module ccd_file_regs #(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 8
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  // contents are undefined after reset, as in the real data memory
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule : ccd_file_regs
`default_nettype wire

// >>> verilog/ccd_return_stack.sv
// circular return address stack; overflow wraps over the oldest entry
`timescale 1ns/1ps
`default_nettype none
module ccd_return_stack #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 15
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          push,
  input  wire logic [AW-1:0] push_addr,
  output logic      [AW-1:0] top
);

  logic [AW-1:0]            entry [DEPTH];
  logic [$clog2(DEPTH)-1:0] ptr;

  // ptr points at the current top entry
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ptr <= '0;
    end else if (push) begin
      ptr <= ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      entry[ptr + 1'b1] <= push_addr;
    end
  end

  assign top = entry[ptr];

endmodule : ccd_return_stack
`default_nettype wire

// >>> verilog/ccd_exec.sv
// execution core for the clear, call and decrement instruction group
//
// Behaviour
// - watchdog clear op resets the watchdog counter to zero
// - watchdog clear op also clears the watchdog prescaler
// - watchdog clear op sets timeout flag and power down flag
// - call via working op pushes program counter plus one onto stack
// - call loads working into pc low, latch low seven bits into pc high
// - call via working op takes two instruction cycles
// - complement writes inverted file value to working or file by d
// - clear file op writes zero to file register, sets zero flag
// - decrement writes file minus one to working or file by d
// - clear working op writes zero to working, sets zero flag
// - decrement skip writes result; zero result skips next, two cycles
`timescale 1ns/1ps
`default_nettype none
module ccd_exec #(
  parameter int unsigned STACK_DEPTH = ccd_pkg::STACK_D,
  parameter int unsigned PRESC_BITS  = ccd_pkg::PRESC_W
) (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic [ccd_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [ccd_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [ccd_pkg::DATA_W-1:0]   reg_rdata,
  output logic                              watchdog_expired
);
  import ccd_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [BYTE_W-1:0]   working;
  logic [PC_W-1:0]     pc;
  logic [LATCH_W-1:0]  program_counter_high_latch;
  logic                zero_flag;
  logic                timeout_flag;
  logic                power_down_flag;
  logic                busy;
  logic [WDT_W-1:0]    watchdog_counter;
  logic [PRESC_BITS-1:0] watchdog_prescaler;
  logic [CYC_W-1:0]    cycles;
  logic [FILE_AW-1:0]  file_addr;

  // ************************************************************
  // decode of the issued instruction
  // ************************************************************
  function automatic logic is_write(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] r);
    return reg_wr && (a == r);
  endfunction : is_write

  logic              issue;
  ccd_op_t           op;
  logic              dest_file;
  logic [FILE_AW-1:0] op_file;
  logic [BYTE_W-1:0] file_value;
  logic [BYTE_W-1:0] result;
  logic              result_zero;
  logic              writes_result;
  logic              skip_taken;

  // an issue while the second cycle of a two-cycle op runs is dropped
  assign issue     = is_write(reg_addr, REG_INSTR) && !busy;
  assign op        = ccd_op_t'(reg_wdata[INSTR_OP_LSB +: 3]);
  assign dest_file = reg_wdata[INSTR_D_BIT];
  assign op_file   = reg_wdata[FILE_AW-1:0];

  // ************************************************************
  // result path
  // ************************************************************
  always_comb begin
    result        = ZERO_BYTE;
    writes_result = 1'b0;
    unique case (op)
      complement_file_op: begin
        result        = ~file_value;
        writes_result = 1'b1;
      end
      decrement_file_op, decrement_skip_zero_op: begin
        result        = file_value - 8'h01;
        writes_result = 1'b1;
      end
      clear_file_op, clear_working_op: begin
        result        = ZERO_BYTE;
        writes_result = 1'b1;
      end
      no_operation, watchdog_clear_op, call_via_working_op: begin
        result        = ZERO_BYTE;
        writes_result = 1'b0;
      end
    endcase
  end

  assign result_zero = (result == ZERO_BYTE);
  assign skip_taken  = issue && (op == decrement_skip_zero_op)
                       && result_zero;

  // ************************************************************
  // file register space
  // ************************************************************
  logic              file_wr;
  logic [FILE_AW-1:0] file_wr_addr;
  logic [BYTE_W-1:0] file_wr_data;
  logic [FILE_AW-1:0] file_rd_addr;

  // clear file always targets the file, the d bit is not used there
  always_comb begin
    file_wr      = 1'b0;
    file_wr_addr = file_addr;
    file_wr_data = reg_wdata[BYTE_W-1:0];
    if (issue && writes_result) begin
      file_wr_addr = op_file;
      file_wr_data = result;
      file_wr      = (op == clear_file_op)
                     || (dest_file && op != clear_working_op);
    end else if (is_write(reg_addr, REG_FILE_DATA)) begin
      file_wr = 1'b1;
    end
  end

  // the operand is read in the issue cycle, the bus view otherwise
  assign file_rd_addr = is_write(reg_addr, REG_INSTR) ? op_file : file_addr;

  ccd_file_regs #(
    .AW (FILE_AW),
    .DW (BYTE_W)
  ) u_file_regs (
    .clk     (clk),
    .wr_en   (file_wr),
    .wr_addr (file_wr_addr),
    .wr_data (file_wr_data),
    .rd_addr (file_rd_addr),
    .rd_data (file_value)
  );

  // ************************************************************
  // return stack
  // ************************************************************
  logic            push;
  logic [PC_W-1:0] return_stack_top;

  assign push = issue && (op == call_via_working_op);

  // pc + 1 is the address of the instruction after the call
  ccd_return_stack #(
    .DEPTH (STACK_DEPTH),
    .AW    (PC_W)
  ) u_return_stack (
    .clk       (clk),
    .resetn    (resetn),
    .push      (push),
    .push_addr (pc + PC_STEP),
    .top       (return_stack_top)
  );

  // ************************************************************
  // working register
  // ************************************************************
  // clear working ignores d; clear file never touches working
  always_ff @(posedge clk) begin
    if (!resetn) begin
      working <= ZERO_BYTE;
    end else if (issue && op == clear_working_op) begin
      working <= ZERO_BYTE;
    end else if (issue && writes_result && !dest_file
                 && op != clear_file_op) begin
      working <= result;
    end else if (is_write(reg_addr, REG_WORK)) begin
      working <= reg_wdata[BYTE_W-1:0];
    end
  end

  // ************************************************************
  // program counter and latch
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pc <= PC_RESET;
    end else if (push) begin
      pc <= {program_counter_high_latch, working};
    end else if (skip_taken) begin
      pc <= pc + PC_SKIP_STEP;
    end else if (issue) begin
      pc <= pc + PC_STEP;
    end else if (is_write(reg_addr, REG_PC)) begin
      pc <= reg_wdata[PC_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      program_counter_high_latch <= '0;
    end else if (is_write(reg_addr, REG_LATCH)) begin
      program_counter_high_latch <= reg_wdata[LATCH_W-1:0];
    end
  end

  // ************************************************************
  // two-cycle timing
  // ************************************************************
  // the second cycle is an internal no-operation; issues are refused
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy <= 1'b0;
    end else begin
      busy <= push || skip_taken;
    end
  end

  // busy cycles count too, so a two-cycle op shows up as two
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cycles <= '0;
    end else if (issue || busy) begin
      cycles <= cycles + 1'b1;
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      zero_flag <= 1'b0;
    end else if (issue && (op == clear_file_op
                           || op == clear_working_op)) begin
      zero_flag <= 1'b1;
    end else if (issue && (op == complement_file_op
                           || op == decrement_file_op)) begin
      zero_flag <= result_zero;
    end else if (is_write(reg_addr, REG_STATUS)) begin
      zero_flag <= reg_wdata[ST_ZERO];
    end
    // skip and call leave the flag alone
  end

  logic wdt_clear;
  logic wdt_tick;
  logic wdt_wrap;

  assign wdt_clear = issue && (op == watchdog_clear_op);
  assign wdt_tick  = &watchdog_prescaler;
  assign wdt_wrap  = wdt_tick && (&watchdog_counter);

  // the clear op wins over a timeout in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      timeout_flag    <= 1'b1;
      power_down_flag <= 1'b1;
    end else if (wdt_clear) begin
      timeout_flag    <= 1'b1;
      power_down_flag <= 1'b1;
    end else if (wdt_wrap) begin
      timeout_flag    <= 1'b0;
    end
  end

  // ************************************************************
  // watchdog counter and prescaler
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      watchdog_prescaler <= '0;
    end else if (wdt_clear) begin
      watchdog_prescaler <= '0;
    end else begin
      watchdog_prescaler <= watchdog_prescaler + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      watchdog_counter <= WDT_CLEAR_VALUE;
    end else if (wdt_clear) begin
      watchdog_counter <= WDT_CLEAR_VALUE;
    end else if (wdt_tick) begin
      watchdog_counter <= watchdog_counter + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      watchdog_expired <= 1'b0;
    end else begin
      watchdog_expired <= wdt_wrap && !wdt_clear;
    end
  end

  // ************************************************************
  // file address pointer for bus access
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      file_addr <= '0;
    end else if (is_write(reg_addr, REG_FILE_ADDR)) begin
      file_addr <= reg_wdata[FILE_AW-1:0];
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  // instruction index and unmapped indices read as zero
  logic [DATA_W-1:0] read_mux;

  always_comb begin
    read_mux = '0;
    unique case (reg_addr)
      REG_WORK:      read_mux[BYTE_W-1:0] = working;
      REG_STATUS: begin
        read_mux[ST_ZERO] = zero_flag;
        read_mux[ST_TO]   = timeout_flag;
        read_mux[ST_PD]   = power_down_flag;
        read_mux[ST_BUSY] = busy;
      end
      REG_PC:        read_mux[PC_W-1:0] = pc;
      REG_LATCH:     read_mux[LATCH_W-1:0] = program_counter_high_latch;
      REG_STACK_TOP: read_mux[PC_W-1:0] = return_stack_top;
      REG_WDT:       read_mux[WDT_W-1:0] = watchdog_counter;
      REG_CYCLES:    read_mux = cycles;
      REG_FILE_ADDR: read_mux[FILE_AW-1:0] = file_addr;
      REG_FILE_DATA: read_mux[BYTE_W-1:0] = file_value;
      default:       read_mux = '0;
    endcase
  end

  // data stand for exactly the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : ccd_exec
`default_nettype wire

// >>> test/ccd_exec_properties.sv
// port-level assertions for the clear, call and decrement core
`timescale 1ns/1ps
`default_nettype none
module ccd_exec_props #(
  parameter int unsigned STACK_DEPTH = 16,
  parameter int unsigned PRESC_BITS  = 8
) (
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire logic [ccd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ccd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [ccd_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       watchdog_expired
);
  import ccd_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence issue_s(logic [2:0] op);
    reg_wr && reg_addr == REG_INSTR && reg_wdata[10:8] == op;
  endsequence

  sequence read_s(logic [3:0] a);
    reg_rd && reg_addr == a;
  endsequence

  // ************************************************************
  // assertions
  // ************************************************************
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  write_only_a: assert property (reg_rd && (reg_addr == REG_INSTR ||
    reg_addr > REG_FILE_DATA) |=> reg_rdata == 16'h0000)
    else $error("instruction or unmapped read not zero");
  // three idle edges: holds for any prescaler of two bits or more
  wdt_cleared_a: assert property (
    issue_s(watchdog_clear_op) ##3 read_s(REG_WDT)
    |=> reg_rdata == 16'h0000)
    else $error("watchdog counter not cleared");
  flags_set_a: assert property (
    issue_s(watchdog_clear_op) ##1 read_s(REG_STATUS)
    |=> reg_rdata[2:1] == 2'b11)
    else $error("timeout or power down flag not set");
  no_expire_a: assert property (
    issue_s(watchdog_clear_op) |-> ##2 !watchdog_expired [*7])
    else $error("expiry right after watchdog clear");
  expired_pulse_a: assert property (watchdog_expired |=> !watchdog_expired)
    else $error("expiry pulse longer than one cycle");
  clear_zero_a: assert property (
    (issue_s(clear_file_op) or issue_s(clear_working_op))
    ##1 read_s(REG_STATUS) |=> reg_rdata[0])
    else $error("zero flag not set by clear");
  call_busy_a: assert property (
    issue_s(call_via_working_op) ##1 read_s(REG_STATUS) |=> reg_rdata[3])
    else $error("call not in its second cycle");

  call_c: cover property (issue_s(call_via_working_op));
  skip_c: cover property (issue_s(decrement_skip_zero_op));
  expire_c: cover property (watchdog_expired);
endmodule : ccd_exec_props
`default_nettype wire

// >>> test/ccd_exec_bench.sv
// self-checking bench for the clear, call and decrement core
`timescale 1ns/1ps
`default_nettype none
module ccd_exec_bench;
  import ccd_pkg::*;

  // ************************************************************
  // stimulus and state
  // ************************************************************
  logic        clk;
  logic        resetn;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        watchdog_expired;
  int          error_cnt;
  int          compares;
  int          ncyc;
  logic        seen;

  // short prescaler keeps the watchdog expiry near a thousand cycles
  ccd_exec #(.STACK_DEPTH(16), .PRESC_BITS(2)) u_ccd_exec (
    .clk             (clk),
    .resetn          (resetn),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .watchdog_expired(watchdog_expired)
  );

  always #2 clk = ~clk;

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // strobe stays up so writes can follow back to back
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask : wr

  // one idle cycle after each read keeps every change on a rising edge
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
    @(posedge clk);
  endtask : rd

  task automatic issue(input logic [2:0] op, input logic d,
                       input logic [6:0] f, input int n);
    wr(REG_INSTR, {5'h00, op, d, f});
    ncyc += n;
  endtask : issue

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    #20000;
    error_cnt++;
    $display("timeout at %0t", $time);
    finish_test();
  end

  initial begin
    clk = 1'b0; resetn = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
    reg_wr = 1'b0; reg_rd = 1'b0;
    error_cnt = 0; compares = 0; ncyc = 0; seen = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(REG_STATUS, 16'h0006);
    rd(REG_INSTR, 16'h0000);
    wr(4'ha, 16'hffff);
    rd(4'ha, 16'h0000);
    done("reset");
    wr(REG_FILE_ADDR, 16'h0005);
    wr(REG_FILE_DATA, 16'h00a5);
    issue(complement_file_op, 1'b0, 7'h05, 1);
    rd(REG_WORK, 16'h005a);
    rd(REG_STATUS, 16'h0006);
    rd(REG_FILE_DATA, 16'h00a5);
    wr(REG_FILE_DATA, 16'h00ff);
    issue(complement_file_op, 1'b1, 7'h05, 1);
    rd(REG_FILE_DATA, 16'h0000);
    rd(REG_STATUS, 16'h0007);
    done("complement");
    wr(REG_FILE_DATA, 16'h0001);
    issue(decrement_file_op, 1'b0, 7'h05, 1);
    rd(REG_STATUS, 16'h0007);
    rd(REG_WORK, 16'h0000);
    issue(decrement_file_op, 1'b1, 7'h05, 1);
    issue(decrement_file_op, 1'b1, 7'h05, 1);
    rd(REG_FILE_DATA, 16'h00ff);
    rd(REG_STATUS, 16'h0006);
    done("decrement");
    wr(REG_FILE_DATA, 16'h0033);
    wr(REG_STATUS, 16'h0000);
    issue(clear_file_op, 1'b0, 7'h05, 1);
    rd(REG_STATUS, 16'h0007);
    rd(REG_FILE_DATA, 16'h0000);
    wr(REG_WORK, 16'h0044);
    wr(REG_STATUS, 16'h0000);
    issue(clear_working_op, 1'b0, 7'h00, 1);
    rd(REG_STATUS, 16'h0007);
    rd(REG_WORK, 16'h0000);
    done("clear");
    wr(REG_PC, 16'h1234);
    wr(REG_LATCH, 16'h0055);
    wr(REG_WORK, 16'h00c3);
    wr(REG_STATUS, 16'h0000);
    issue(call_via_working_op, 1'b0, 7'h00, 2);
    issue(clear_working_op, 1'b0, 7'h00, 0);  // refused while busy
    rd(REG_PC, 16'h55c3);
    rd(REG_STACK_TOP, 16'h1235);
    rd(REG_WORK, 16'h00c3);
    rd(REG_STATUS, 16'h0006);
    issue(call_via_working_op, 1'b0, 7'h00, 2);
    rd(REG_STATUS, 16'h000e);
    rd(REG_STACK_TOP, 16'h55c4);
    rd(REG_CYCLES, ncyc[15:0]);
    done("call");
    wr(REG_PC, 16'h0100);
    wr(REG_STATUS, 16'h0001);
    wr(REG_FILE_DATA, 16'h0002);
    issue(decrement_skip_zero_op, 1'b1, 7'h05, 1);
    rd(REG_STATUS, 16'h0007);
    issue(no_operation, 1'b0, 7'h00, 1);
    wr(REG_STATUS, 16'h0000);
    issue(decrement_skip_zero_op, 1'b1, 7'h05, 2);
    rd(REG_STATUS, 16'h000e);
    rd(REG_PC, 16'h0104);
    rd(REG_FILE_DATA, 16'h0000);
    rd(REG_CYCLES, ncyc[15:0]);
    done("skip");
    for (int i = 0; i < 1500 && !seen; i++) begin
      @(negedge clk);
      seen = watchdog_expired;
    end
    @(posedge clk);
    chk({15'h0000, seen}, 16'h0001);
    rd(REG_STATUS, 16'h0004);
    issue(watchdog_clear_op, 1'b0, 7'h00, 1);
    rd(REG_STATUS, 16'h0006);
    rd(REG_WDT, 16'h0000);
    rd(REG_CYCLES, ncyc[15:0]);
    done("watchdog");
    finish_test();
  end
endmodule : ccd_exec_bench

bind ccd_exec ccd_exec_props #(
  .STACK_DEPTH(STACK_DEPTH),
  .PRESC_BITS (PRESC_BITS)
) u_ccd_exec_props (
  .clk             (clk),
  .resetn          (resetn),
  .reg_addr        (reg_addr),
  .reg_wdata       (reg_wdata),
  .reg_wr          (reg_wr),
  .reg_rd          (reg_rd),
  .reg_rdata       (reg_rdata),
  .watchdog_expired(watchdog_expired)
);
`default_nettype wire
